// ### core/monitor_map.svh
// Purpose: Register offsets, field positions, reset values and timing constants
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Times in their own units, cycle counts derived from the clock rate
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

`define CLK_MHZ          200
`define WIN_US           1000
`define WIN_CYC          (`WIN_US * `CLK_MHZ)
`define STOP_US          10
`define STOP_CYC         (`STOP_US * `CLK_MHZ)

`define OFS_ENC_CFG      12'h000
`define OFS_GRID         12'h004
`define OFS_PPR          12'h008
`define OFS_PITCH        12'h00C
`define OFS_FREQ_LIM     12'h010
`define OFS_STILL_TOL    12'h014
`define OFS_CTRL         12'h018
`define OFS_STATUS       12'h01C
`define OFS_MASK         12'h020
`define OFS_POS          12'h024
`define OFS_SPEED        12'h028
`define OFS_STATE        12'h02C
`define OFS_VLIM         12'h040
`define OFS_NUM          12'h060
`define OFS_DEN          12'h080
`define VLIM_SPAN        12'h010
`define RATIO_SPAN       12'h020

`define CFG_LINEAR       0
`define CFG_INVERT       1
`define CFG_DUAL         2
`define CFG_USED         3

`define CTRL_LOCK        0
`define CTRL_LIN_AXIS    1
`define CTRL_ACK         2

`define ST_SPEED         0
`define ST_FREQ          1
`define ST_STILL         2
`define ST_BITS          3

`define IN_SOS           0
`define IN_SRS           1
`define IN_STAGE         2
`define IN_GEAR          4

`define RST_GRID_NM      32'h0000_2710
`define RST_PPR          32'h0000_0800
`define RST_PITCH_UM     32'h0000_2710
`define RST_RATIO        32'h0000_0001
`define RST_FREQ_LIM     32'h0004_93E0
`define RST_STILL_TOL    32'h0000_03E8
`define RST_VLIM         32'h0000_07D0

`define K_LIN_POS        96'h1
`define K_LIN_SPD        96'h3C
`define K_ROT_POS        96'h5_7E40
`define K_ROT_SPD        96'hEA60
`define K_NM_PER_UM      96'h3E8
`define K_MS_PER_S       96'h3E8

`endif

// ### core/monitor_pkg.sv
// Purpose: Types shared by the motion monitor
// Assumes: Nothing
// Notes:   State codes follow declaration order, MON_RUN is 0
package monitor_pkg;
   typedef enum logic [1:0] {
      MON_RUN,
      MON_STOP_RESP,
      MON_SOS,
      MON_STANDSTILL
   } mon_state_t;
endpackage : monitor_pkg

// ### core/safe_encoder_motion_monitor.sv
// Purpose: Safe position, speed and encoder-frequency monitor for one axis
// Assumes: Quadrature encoder pins and safety inputs are asynchronous
// Notes:   Configuration freezes when the lock bit is set, until reset
`timescale 1ns/10ps
`include "monitor_map.svh"

// Notes on behaviour
// - Config bit 0 selects linear encoder
// - Config bit 1 inverts encoder count sign
// - Dual-encoder bit skips frequency supervision
// - Grid spacing used only for linear encoders
// - Rotary scaling uses pulses per revolution
// - Leadscrew pitch converts revolutions to travel
// - Eight gear pairs, chosen by safety inputs
// - Numerator encoder revolutions, denominator load revolutions
// - Configurable encoder limit frequency, default 300000
// - Leaving standstill window forces safe standstill
// - Four reduced-speed limits, default 2000
// - Overspeed starts stop response, then safe stop
// - Encoder overfrequency on single encoder stops drive
module safe_encoder_motion_monitor
   import monitor_pkg::*;
#(
   parameter int WIN_CYCLES  = `WIN_CYC,
   parameter int STOP_CYCLES = `STOP_CYC
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic [6:0]  safety_input_signal,
   output logic             stop_request,
   output logic             safe_operating_stop,
   output logic             safe_standstill,
   output logic             irq
);
   logic [2:0]  enc_cfg_r;
   logic [31:0] grid_r, ppr_r, pitch_r, freq_lim_r, still_tol_r;
   logic [31:0] vlim_r [4];
   logic [31:0] num_r [8];
   logic [31:0] den_r [8];
   logic        lock_r, lin_axis_r;
   logic [`ST_BITS-1:0] status_r, mask_r;
   mon_state_t  state_r, state_nxt;

   logic [1:0]  a_s_r, b_s_r;
   logic [6:0]  in_s1_r, in_s2_r;
   logic        a_d_r, b_d_r;
   logic signed [31:0] pos_r, win_start_r, hold_r, speed_r;
   logic [31:0] edges_r, win_cnt_r, stop_cnt_r;
   logic        win_tick_r;

   // True when the address is an aligned word inside a block of registers
   function automatic logic in_block(
      input logic [11:0] addr,
      input logic [11:0] base,
      input logic [11:0] span
   );
      return (addr >= base) && (addr < base + span)
             && (addr[1:0] == 2'b00);
   endfunction : in_block

   // Bus decode
   wire acc     = psel & penable & ce;
   wire wr      = acc & pwrite;
   wire cfg_wr  = wr & ~lock_r;
   wire in_vlim = in_block(paddr, `OFS_VLIM, `VLIM_SPAN);
   wire in_num  = in_block(paddr, `OFS_NUM, `RATIO_SPAN);
   wire in_den  = in_block(paddr, `OFS_DEN, `RATIO_SPAN);
   wire [2:0] idx = paddr[4:2];
   wire hit_fix = (paddr <= `OFS_STATE) && (paddr[1:0] == 2'b00);
   wire mapped  = hit_fix | in_vlim | in_num | in_den;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Synchronised pins
   wire a_q = a_s_r[1];
   wire b_q = b_s_r[1];
   wire [6:0] sin = in_s2_r;
   wire sos_sel   = sin[`IN_SOS];
   wire srs_sel   = sin[`IN_SRS];
   wire [1:0] stage = sin[`IN_STAGE +: 2];
   wire [2:0] gear  = sin[`IN_GEAR +: 3];

   // Quadrature decode, x4; pin edges must stay one or more cycles apart
   // for every edge to be counted
   wire step   = (a_q ^ a_d_r) | (b_q ^ b_d_r);
   wire dir_up = a_q ^ b_d_r;
   wire up_eff = dir_up ^ enc_cfg_r[`CFG_INVERT];

   wire [31:0] num_sel = num_r[gear];
   wire [31:0] den_sel = den_r[gear];

   // True when a count excursion exceeds a limit in load units
   function automatic logic exceeds(
      input logic [31:0] delta,
      input logic [31:0] lim,
      input logic        speed
   );
      logic [95:0] lhs;
      logic [95:0] rhs;
      lhs = '0;
      rhs = '0;
      if (enc_cfg_r[`CFG_LINEAR])
      begin
         // Linear scale: grid spacing in nm per count
         lhs = 96'(delta) * 96'(grid_r) * (speed ? `K_LIN_SPD : `K_LIN_POS);
         rhs = 96'(lim) * `K_NM_PER_UM;
      end
      else if (lin_axis_r)
      begin
         // Rotary encoder on leadscrew: um = cnt*den*pitch/(ppr*num)
         lhs = 96'(delta) * 96'(den_sel) * 96'(pitch_r) * (speed ? `K_LIN_SPD : `K_LIN_POS);
         rhs = 96'(lim) * 96'(ppr_r) * 96'(num_sel);
      end
      else
      begin
         // Rotary axis in millidegrees or rev/min
         lhs = 96'(delta) * 96'(den_sel) * (speed ? `K_ROT_SPD : `K_ROT_POS);
         rhs = 96'(lim) * 96'(ppr_r) * 96'(num_sel);
      end
      return lhs > rhs;
   endfunction : exceeds

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      return v[31] ? 32'(-v) : 32'(v);
   endfunction : mag

   // Monitoring
   wire monitoring = lock_r;
   wire sg_active  = monitoring & srs_sel & (state_r == MON_RUN);
   wire sos_active = monitoring & (sos_sel | (state_r == MON_SOS));
   // Violation checks sit in a process so that they also follow the
   // configuration registers that exceeds() reads
   logic speed_viol;
   logic freq_viol;
   logic still_viol;
   always_comb
   begin
      speed_viol = win_tick_r & sg_active
                   & exceeds(mag(speed_r), vlim_r[stage], 1'b1);
      freq_viol  = win_tick_r & monitoring & ~enc_cfg_r[`CFG_DUAL]
                   & (srs_sel | sos_active)
                   & (96'(edges_r) * `K_MS_PER_S > 96'(freq_lim_r));
      still_viol = sos_active & (state_r != MON_STANDSTILL)
                   & exceeds(mag(pos_r - hold_r), still_tol_r, 1'b0);
   end
   wire ack        = wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_ACK];
   wire stop_done  = (stop_cnt_r >= 32'(STOP_CYCLES - 1));

   // Run, stop response, safe operating stop; standstill holds until reset
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         MON_RUN:
            if (still_viol)
               state_nxt = MON_STANDSTILL;
            else if (speed_viol | freq_viol)
               state_nxt = MON_STOP_RESP;
         MON_STOP_RESP:
            if (stop_done)
               state_nxt = MON_SOS;
         MON_SOS:
            if (still_viol)
               state_nxt = MON_STANDSTILL;
            else if (ack)
               state_nxt = MON_RUN;
         default:
            state_nxt = MON_STANDSTILL;
      endcase
   end

   wire [`ST_BITS-1:0] ev = {still_viol, freq_viol, speed_viol};
   wire st_wr = wr && (paddr == `OFS_STATUS);
   // Sticky status bits, cleared by a one; an event in the clearing cycle wins
   logic [`ST_BITS-1:0] status_nxt;
   for (genvar i = 0; i < `ST_BITS; i++)
   begin : g_status
      assign status_nxt[i] = ev[i] | (status_r[i] & ~(st_wr & pwdata[i]));
   end

   assign irq                 = |(status_r & mask_r);
   assign stop_request        = (state_r == MON_STOP_RESP);
   assign safe_operating_stop = (state_r == MON_SOS) | sos_active;
   assign safe_standstill     = (state_r == MON_STANDSTILL);

   // Read mux
   logic [31:0] rdata_nxt;
   always_comb
   begin
      rdata_nxt = '0;
      if (paddr == `OFS_ENC_CFG)
         rdata_nxt = {29'h0, enc_cfg_r};
      else if (paddr == `OFS_GRID)
         rdata_nxt = grid_r;
      else if (paddr == `OFS_PPR)
         rdata_nxt = ppr_r;
      else if (paddr == `OFS_PITCH)
         rdata_nxt = pitch_r;
      else if (paddr == `OFS_FREQ_LIM)
         rdata_nxt = freq_lim_r;
      else if (paddr == `OFS_STILL_TOL)
         rdata_nxt = still_tol_r;
      else if (paddr == `OFS_CTRL)
         rdata_nxt = {30'h0, lin_axis_r, lock_r};
      else if (paddr == `OFS_STATUS)
         rdata_nxt = {29'h0, status_r};
      else if (paddr == `OFS_MASK)
         rdata_nxt = {29'h0, mask_r};
      else if (paddr == `OFS_POS)
         rdata_nxt = pos_r;
      else if (paddr == `OFS_SPEED)
         rdata_nxt = speed_r;
      else if (paddr == `OFS_STATE)
         rdata_nxt = {30'h0, state_r};
      else if (in_vlim)
         rdata_nxt = vlim_r[idx[1:0]];
      else if (in_num)
         rdata_nxt = num_r[idx];
      else if (in_den)
         rdata_nxt = den_r[idx];
   end
   // Read data is taken from the mux in the setup phase and stands through
   // the access phase; between transfers it reads zero
   logic [31:0] prdata_r;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prdata_r <= '0;
      else if (ce)
         prdata_r <= (psel & ~penable & mapped) ? rdata_nxt : '0;
   assign prdata = prdata_r;

   // Encoder synchronisers carry no reset, so a pin that stays high across
   // a reset gives no false count edge when reset is released
   always_ff @(posedge pclk)
      if (ce)
      begin
         a_s_r <= {a_s_r[0], enc_a};
         b_s_r <= {b_s_r[0], enc_b};
         a_d_r <= a_q;
         b_d_r <= b_q;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         in_s1_r <= '0;
         in_s2_r <= '0;
      end
      else if (ce)
      begin
         in_s1_r <= safety_input_signal;
         in_s2_r <= in_s1_r;
      end

   // Position, window and speed
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pos_r       <= '0;
         win_start_r <= '0;
         speed_r     <= '0;
         edges_r     <= '0;
         win_cnt_r   <= '0;
         win_tick_r  <= 1'b0;
      end
      else if (ce)
      begin
         if (step)
            pos_r <= up_eff ? pos_r + 32'sd1 : pos_r - 32'sd1;
         win_tick_r <= (win_cnt_r == 32'(WIN_CYCLES - 1));
         if (win_cnt_r == 32'(WIN_CYCLES - 1))
         begin
            win_cnt_r   <= '0;
            speed_r     <= pos_r - win_start_r;
            win_start_r <= pos_r;
            // The closing cycle's edge still belongs to this window
            edges_r     <= edges_r + {31'h0, step};
         end
         else
         begin
            win_cnt_r <= win_cnt_r + 32'd1;
            if (step && !win_tick_r)
               edges_r <= edges_r + 32'd1;
            else if (win_tick_r)
               edges_r <= {31'h0, step};
         end
      end

   // Monitor state and standstill reference
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state_r    <= MON_RUN;
         stop_cnt_r <= '0;
         hold_r     <= '0;
         status_r   <= '0;
      end
      else if (ce)
      begin
         state_r    <= state_nxt;
         status_r   <= status_nxt;
         stop_cnt_r <= (state_r == MON_STOP_RESP) ? stop_cnt_r + 32'd1 : '0;
         if (!sos_active)
            hold_r <= pos_r;
      end

   // Software registers
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         enc_cfg_r   <= '0;
         grid_r      <= `RST_GRID_NM;
         ppr_r       <= `RST_PPR;
         pitch_r     <= `RST_PITCH_UM;
         freq_lim_r  <= `RST_FREQ_LIM;
         still_tol_r <= `RST_STILL_TOL;
         lock_r      <= 1'b0;
         lin_axis_r  <= 1'b0;
         mask_r      <= '0;
         for (int i = 0; i < 4; i++)
            vlim_r[i] <= `RST_VLIM;
         for (int i = 0; i < 8; i++)
         begin
            num_r[i] <= `RST_RATIO;
            den_r[i] <= `RST_RATIO;
         end
      end
      else if (ce)
      begin
         if (wr && paddr == `OFS_MASK)
            mask_r <= pwdata[`ST_BITS-1:0];
         if (wr && paddr == `OFS_CTRL && pwdata[`CTRL_LOCK])
            lock_r <= 1'b1;
         if (cfg_wr)
         begin
            if (paddr == `OFS_ENC_CFG)
               enc_cfg_r <= pwdata[`CFG_USED-1:0];
            else if (paddr == `OFS_GRID)
               grid_r <= pwdata;
            else if (paddr == `OFS_PPR)
               ppr_r <= pwdata;
            else if (paddr == `OFS_PITCH)
               pitch_r <= pwdata;
            else if (paddr == `OFS_FREQ_LIM)
               freq_lim_r <= pwdata;
            else if (paddr == `OFS_STILL_TOL)
               still_tol_r <= pwdata;
            else if (paddr == `OFS_CTRL)
               lin_axis_r <= pwdata[`CTRL_LIN_AXIS];
            else if (in_vlim)
               vlim_r[idx[1:0]] <= pwdata;
            else if (in_num)
               num_r[idx] <= pwdata;
            else if (in_den)
               den_r[idx] <= pwdata;
         end
      end
endmodule : safe_encoder_motion_monitor

// ### bench/monitor_asserts.sv
// Purpose: Port-level checks for the motion monitor
// Assumes: Parameters handed on from the bound instance
// Notes:   Bound onto every instance of the monitor
`timescale 1ns/10ps
module monitor_asserts #(
   parameter int WIN_CYCLES  = 200,
   parameter int STOP_CYCLES = 8
)(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        enc_a,
   input wire logic        enc_b,
   input wire logic [6:0]  safety_input_signal,
   input wire logic        stop_request,
   input wire logic        safe_operating_stop,
   input wire logic        safe_standstill,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] stop_cnt_r;
   // Counts enabled cycles of one stop response
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         stop_cnt_r <= 16'h0000;
      else if (!stop_request)
         stop_cnt_r <= 16'h0000;
      else if (ce)
         stop_cnt_r <= stop_cnt_r + 16'h0001;
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access not answered at once");
   cfg_bits_a: assert property (psel && penable && !pwrite && paddr == 12'h000 |-> prdata[31:3] == 29'h0)
      else $error("reserved config bits read nonzero");
   unmapped_a: assert property (psel && penable && paddr == 12'h030 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   freq_map_a: assert property (psel && penable && paddr == 12'h010 |-> !pslverr)
      else $error("limit frequency register refused");
   idle_rdata_a: assert property (!psel |-> prdata == 32'h0)
      else $error("read data driven while idle");
   stop_len_a: assert property (stop_cnt_r <= 16'(STOP_CYCLES))
      else $error("stop response too long");
   stop_then_sos_a: assert property ($fell(stop_request) |-> safe_operating_stop)
      else $error("stop response not followed by safe stop");
   still_hold_a: assert property (safe_standstill |=> safe_standstill)
      else $error("safe standstill released");
endmodule : monitor_asserts

bind safe_encoder_motion_monitor monitor_asserts #(
   .WIN_CYCLES(WIN_CYCLES), .STOP_CYCLES(STOP_CYCLES)
) u_monitor_asserts (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
   .safety_input_signal(safety_input_signal), .stop_request(stop_request),
   .safe_operating_stop(safe_operating_stop), .safe_standstill(safe_standstill), .irq(irq)
);

// ### bench/encoder_model.sv
// Purpose: Quadrature encoder on the axis
// Assumes: Moves only while run is high
// Notes:   Steps every fourth cycle so pin edges stay four cycles apart
`timescale 1ns/10ps
module encoder_model(
   input  wire logic pclk,
   input  wire logic run,
   input  wire logic dir,
   output logic      enc_a,
   output logic      enc_b
);
   logic [1:0] ph_r = 2'h0;
   logic [1:0] div_r = 2'h0;
   always @(posedge pclk)
   begin
      div_r <= div_r + 2'h1;
      if (run && div_r == 2'h3)
         ph_r <= dir ? ph_r + 2'h1 : ph_r - 2'h1;
   end
   // A leads B when counting up
   assign enc_a = ph_r[1] ^ ph_r[0];
   assign enc_b = ph_r[1];
endmodule : encoder_model

// ### bench/tb.sv
// Purpose: Self-checking bench for the motion monitor
// Assumes: Short window and stop counts
// Notes:   Register model kept in an associative array
`timescale 1ns/10ps
`include "monitor_map.svh"
module tb import monitor_pkg::*;;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, enc_a, enc_b, err, run = 0, dir = 1;
   logic stop_request, safe_operating_stop, safe_standstill, irq;
   logic [6:0] safety_input_signal = 0;
   int num_errors = 0, check_count = 0;
   bit locked;
   logic [31:0] exp_m[int];
   always #2.5 pclk = ~pclk;
   safe_encoder_motion_monitor #(.WIN_CYCLES(200), .STOP_CYCLES(8)) u_safe_encoder_motion_monitor (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
      .safety_input_signal(safety_input_signal), .stop_request(stop_request),
      .safe_operating_stop(safe_operating_stop), .safe_standstill(safe_standstill), .irq(irq));
   encoder_model u_encoder_model (.pclk(pclk), .run(run), .dir(dir), .enc_a(enc_a), .enc_b(enc_b));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (!locked && exp_m.exists(a))
         exp_m[a] = (a == `OFS_ENC_CFG) ? (d & 32'h7) : d;
   endtask : wr
   task automatic rdc(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), exp_m[a], rd);
   endtask : rdc
   task automatic wt(input int s);
      int n;
      n = 0;
      while (!(s == 0 ? stop_request : s == 1 ? safe_operating_stop : safe_standstill) && n < 5000)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 5000)
      begin
         $display("mismatch wait %0d expected 1 seen 0", s);
         num_errors++;
      end
      repeat (2) @(posedge pclk);
   endtask : wt
   task automatic rst();
      presetn <= 1'b0;
      locked = 0;
      exp_m = '{`OFS_ENC_CFG: 32'h0, `OFS_GRID: `RST_GRID_NM, `OFS_PPR: `RST_PPR,
         `OFS_PITCH: `RST_PITCH_UM, `OFS_FREQ_LIM: `RST_FREQ_LIM, `OFS_STILL_TOL: `RST_STILL_TOL};
      for (int i = 0; i < 8; i++)
      begin
         if (i < 4)
            exp_m[`OFS_VLIM + 4 * i] = `RST_VLIM;
         exp_m[`OFS_NUM + 4 * i] = `RST_RATIO;
         exp_m[`OFS_DEN + 4 * i] = `RST_RATIO;
      end
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic lock_and_run(input logic [6:0] sel, input int s);
      safety_input_signal <= sel | 7'(($urandom % 8) << `IN_GEAR);
      wr(`OFS_CTRL, 32'h1);
      locked = 1;
      repeat (20) @(posedge pclk);
      run <= 1'b1;
      wt(s);
      run <= 1'b0;
   endtask : lock_and_run
   initial
   begin
      #200000;
      num_errors++;
      close_out();
   end
   initial
   begin
      void'($urandom(32'h1a82122f));
      rst();
      foreach (exp_m[a]) rdc(12'(a));
      $display("test reset values done");
      wr(`OFS_PPR, 1 + $urandom % 100000);
      for (int i = 0; i < 8; i++)
         wr(`OFS_NUM + 4 * i, 1 + $urandom % 8388607);
      wr(`OFS_ENC_CFG, 32'h0000_0007);
      foreach (exp_m[a]) rdc(12'(a));
      apb(1'b0, 12'h030, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      wr(`OFS_CTRL, 32'h1);
      locked = 1;
      wr(`OFS_PPR, 32'h5);
      wr(`OFS_ENC_CFG, 32'h0);
      foreach (exp_m[a]) rdc(12'(a));
      $display("test registers done");
      rst();
      wr(`OFS_ENC_CFG, 32'h1);
      wr(`OFS_VLIM + 8, 32'h0);
      wr(`OFS_FREQ_LIM, 32'h1);
      wr(`OFS_MASK, 32'h7);
      lock_and_run(7'h0A, 0);
      chk("stop", 32'h1, {31'h0, stop_request});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("status", 32'h3, rd);
      wt(1);
      chk("sos", 32'h1, {31'h0, safe_operating_stop});
      apb(1'b0, `OFS_POS, 32'h0);
      chk("pos sign", 32'h0, {31'h0, rd[31]});
      wr(`OFS_STATUS, 32'h7);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      chk("irq", 32'h0, {31'h0, irq});
      wr(`OFS_CTRL, 32'h5);
      apb(1'b0, `OFS_STATE, 32'h0);
      chk("state", 32'h0, rd);
      $display("test overspeed done");
      rst();
      wr(`OFS_ENC_CFG, 32'h7);
      wr(`OFS_STILL_TOL, 32'h1);
      wr(`OFS_FREQ_LIM, 32'h1);
      wr(`OFS_MASK, 32'h4);
      lock_and_run(7'h01, 2);
      repeat (30) @(posedge pclk);
      chk("standstill", 32'h1, {31'h0, safe_standstill});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("status", 32'h4, rd);
      apb(1'b0, `OFS_POS, 32'h0);
      chk("pos sign", 32'h1, {31'h0, rd[31]});
      $display("test standstill done");
      rst();
      safety_input_signal <= 7'h02;
      wr(`OFS_CTRL, 32'h1);
      run <= 1'b1;
      repeat (1000) @(posedge pclk);
      // One count every fourth cycle gives 50 counts in a 200-cycle window
      apb(1'b0, `OFS_SPEED, 32'h0);
      chk("speed", 32'h32, rd);
      chk("stop", 32'h0, {31'h0, stop_request});
      chk("sos", 32'h0, {31'h0, safe_operating_stop});
      run <= 1'b0;
      $display("test rotary speed done");
      close_out();
   end
endmodule : tb
